// *** design/wrs_pkg.sv ***
// Shared constants and types of the waveform replay sequencer.
package wrs_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int STRB_W    = 4;
  localparam int SMP_W     = 14;
  localparam int MEM_AW    = 8;
  localparam int MEM_DEPTH = 256;
  localparam int SEQ_AW    = 4;
  localparam int SEQ_DEPTH = 16;
  localparam int PW_W      = 16;
  localparam int LOOP_W    = 16;
  localparam int LVL_W     = 9;
  localparam int CTRL_W    = 11;
  localparam int SEQ_W     = 29;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PW     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LAST   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_LOOPS  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_NSEG   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MADDR  = 8'h18;
  localparam logic [ADDR_W-1:0] REG_MDATA  = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_SADDR  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_SDATA  = 8'h24;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h28;

  localparam int CMD_ARM     = 0;
  localparam int CMD_STOP    = 1;
  localparam int CMD_SWTRIG  = 2;
  localparam int CMD_JUMP    = 3;
  localparam int CMD_IDX_LSB = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] TSRC_EXT0 = 2'h0;
  localparam logic [1:0] TSRC_EXT1 = 2'h1;
  localparam logic [1:0] TSRC_SW   = 2'h2;

  localparam logic [LVL_W-1:0] LVL_FULL = 9'h100;
  localparam logic [LVL_W-1:0] LVL_HALF = 9'h080;
  localparam logic [PW_W-1:0]  PW_MAXV  = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_ONESHOT, MODE_REPEAT, MODE_RESTART, MODE_FIFO,
    MODE_MULTI, MODE_GATED, MODE_SEQ
  } wrs_mode_t;

  typedef enum logic [1:0] {PW_OFF, PW_MIN, PW_MAX} wrs_pw_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_PLAY, ST_WAIT, ST_DONE
  } wrs_state_t;

  typedef struct packed {
    logic       clk_out_en;
    logic       trig_out_en;
    wrs_pw_t    pw_mode;
    logic       edge_fall;
    logic       gate_level;
    logic [1:0] trig_src;
    wrs_mode_t  mode;
  } wrs_ctrl_t;

  typedef struct packed {
    logic        wait_trig;
    logic [3:0]  next;
    logic [7:0]  loops;
    logic [7:0]  last;
    logic [7:0]  start;
  } wrs_seq_t;

  typedef struct packed {
    logic             fill_req;
    logic [LVL_W-1:0] level;
    logic [3:0]       seq_idx;
    wrs_state_t       state;
  } wrs_status_t;

  typedef struct packed {
    logic             valid;
    logic [SMP_W-1:0] data;
  } wrs_smp_t;

  localparam wrs_ctrl_t CTRL_RST = '0;

endpackage

// *** design/wrs_sequencer.sv ***
// Waveform replay sequencer with register slave and trigger logic.
// Summary of operation
// - One-shot plays memory once from first trigger.
// - One-shot and repeat ignore later triggers.
// - Repeat replays back to back, programmed passes.
// - Stop command ends repeated playback early.
// - Trigger source: either external input or software.
// - Restart mode plays once per trigger.
// - FIFO mode uses whole memory as ring.
// - FIFO asks host for refill; host refills.
// - Multi mode splits memory into equal segments.
// - Multi mode plays next segment each trigger.
// - Multi mode re-arms itself after each segment.
// - Gated mode plays only at selected gate level.
// - Sequence segments have own start and length.
// - Sequence order comes from separate sequence memory.
// - Each entry repeats its segment loop-count times.
// - Entry may wait for trigger before advancing.
// - Software command jumps to another chain entry.
// - Idle-segment writes during playback never disturb output.
// - Trigger edge rising or falling, optional width.
// - Width check: at least or at most limit.
// - Recognised triggers go to trigger output when enabled.
// - Sampling clock divided by two can drive the clock output.
module wrs_sequencer (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [wrs_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [wrs_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [wrs_pkg::STRB_W-1:0]  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [wrs_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [wrs_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [1:0]                  trig_in,
  input  wire logic                        gate_in,
  output logic                             trig_out,
  output logic                             clk_out,
  output logic                             fill_req,
  output wrs_pkg::wrs_smp_t                smp_out
);

  wrs_pkg::wrs_ctrl_t             ctrl_reg;
  wrs_pkg::wrs_state_t            state_reg;
  wrs_pkg::wrs_seq_t              ent;
  logic [wrs_pkg::PW_W-1:0]       pw_reg;
  logic [wrs_pkg::PW_W-1:0]       pw_cnt_reg;
  logic [7:0]                     last_reg;
  logic [wrs_pkg::LOOP_W-1:0]     loops_reg;
  logic [wrs_pkg::LOOP_W-1:0]     pass_reg;
  logic [3:0]                     nseg_reg;
  logic [3:0]                     seg_reg;
  logic [wrs_pkg::MEM_AW-1:0]     maddr_reg;
  logic [wrs_pkg::MEM_AW-1:0]     fifo_wp_reg;
  logic [wrs_pkg::SEQ_AW-1:0]     saddr_reg;
  logic [wrs_pkg::SEQ_AW-1:0]     seq_idx_reg;
  logic [7:0]                     loop_reg;
  logic [wrs_pkg::MEM_AW-1:0]     off_reg;
  logic [wrs_pkg::MEM_AW-1:0]     base_reg;
  logic [wrs_pkg::LVL_W-1:0]      level_reg;
  logic [wrs_pkg::SMP_W-1:0]      mem [wrs_pkg::MEM_DEPTH];
  wrs_pkg::wrs_seq_t              seq_mem [wrs_pkg::SEQ_DEPTH];
  logic [wrs_pkg::ADDR_W-1:0]     aw_addr_reg;
  logic [wrs_pkg::DATA_W-1:0]     w_data_reg;
  logic [wrs_pkg::STRB_W-1:0]     w_strb_reg;
  logic                           aw_got_reg;
  logic                           w_got_reg;
  logic [1:0]                     trig_s1_reg;
  logic [1:0]                     trig_s2_reg;
  logic                           gate_s1_reg;
  logic                           gate_s2_reg;
  logic                           act_prev_reg;
  logic                           wr_ok;
  logic [wrs_pkg::DATA_W-1:0]     wr_word;
  logic [wrs_pkg::DATA_W-1:0]     cmd;
  logic                           act;
  logic                           ext_evt;
  logic                           trig_evt;
  logic                           is_fifo;
  logic                           is_seq;
  logic                           step;
  logic                           mem_we;
  logic [7:0]                     reg_last;
  logic [wrs_pkg::MEM_AW-1:0]     rd_addr;

  function automatic logic mapped(input logic [wrs_pkg::ADDR_W-1:0] a);
    mapped = a inside {wrs_pkg::REG_CTRL, wrs_pkg::REG_CMD,
                       wrs_pkg::REG_PW, wrs_pkg::REG_LAST,
                       wrs_pkg::REG_LOOPS, wrs_pkg::REG_NSEG,
                       wrs_pkg::REG_MADDR, wrs_pkg::REG_MDATA,
                       wrs_pkg::REG_SADDR, wrs_pkg::REG_SDATA,
                       wrs_pkg::REG_STATUS};
  endfunction

  // Write-only locations read as zero, so strobed merges leave no residue.
  function automatic logic [wrs_pkg::DATA_W-1:0] rd_val(
    input logic [wrs_pkg::ADDR_W-1:0] a);
    wrs_pkg::wrs_status_t st;
    st = '{fill_req: fill_req, level: level_reg,
           seq_idx: seq_idx_reg, state: state_reg};
    unique case (a)
      wrs_pkg::REG_CTRL:   rd_val = 32'(ctrl_reg);
      wrs_pkg::REG_PW:     rd_val = 32'(pw_reg);
      wrs_pkg::REG_LAST:   rd_val = 32'(last_reg);
      wrs_pkg::REG_LOOPS:  rd_val = 32'(loops_reg);
      wrs_pkg::REG_NSEG:   rd_val = 32'(nseg_reg);
      wrs_pkg::REG_MADDR:  rd_val = 32'(maddr_reg);
      wrs_pkg::REG_SADDR:  rd_val = 32'(saddr_reg);
      wrs_pkg::REG_STATUS: rd_val = 32'(st);
      default:             rd_val = '0;
    endcase
  endfunction

  function automatic logic [wrs_pkg::DATA_W-1:0] merge(
    input logic [wrs_pkg::DATA_W-1:0] o,
    input logic [wrs_pkg::DATA_W-1:0] n,
    input logic [wrs_pkg::STRB_W-1:0] s);
    merge = o;
    for (int i = 0; i < wrs_pkg::STRB_W; i++)
    begin
      if (s[i])
        merge[i*8 +: 8] = n[i*8 +: 8];
    end
  endfunction

  assign wr_ok   = aw_got_reg && w_got_reg && !s_axi_bvalid
                   && mapped(aw_addr_reg);
  assign wr_word = merge(rd_val(aw_addr_reg), w_data_reg, w_strb_reg);
  assign cmd     = (wr_ok && aw_addr_reg == wrs_pkg::REG_CMD) ? wr_word
                                                              : '0;

  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= wrs_pkg::RESP_OKAY;
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg   <= s_axi_awaddr;
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_reg && w_got_reg && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_reg) ? wrs_pkg::RESP_OKAY
                                            : wrs_pkg::RESP_SLVERR;
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel: one outstanding read, answered the next cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= wrs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val(s_axi_araddr);
      s_axi_rresp   <= mapped(s_axi_araddr) ? wrs_pkg::RESP_OKAY
                                            : wrs_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg  <= wrs_pkg::CTRL_RST;
      pw_reg    <= '0;
      last_reg  <= '0;
      loops_reg <= '0;
      nseg_reg  <= '0;
    end
    else if (wr_ok)
    begin
      unique case (aw_addr_reg)
        wrs_pkg::REG_CTRL:
          ctrl_reg <= wrs_pkg::wrs_ctrl_t'(wr_word[wrs_pkg::CTRL_W-1:0]);
        wrs_pkg::REG_PW:    pw_reg    <= wr_word[wrs_pkg::PW_W-1:0];
        wrs_pkg::REG_LAST:  last_reg  <= wr_word[7:0];
        wrs_pkg::REG_LOOPS: loops_reg <= wr_word[wrs_pkg::LOOP_W-1:0];
        wrs_pkg::REG_NSEG:  nseg_reg  <= wr_word[3:0];
        default:            ;
      endcase
    end
  end

  assign is_fifo = ctrl_reg.mode == wrs_pkg::MODE_FIFO;
  assign is_seq  = ctrl_reg.mode == wrs_pkg::MODE_SEQ;

  // Sample and sequence memories have their own write port, so loading
  // an idle segment never stalls or corrupts the read side.
  assign mem_we = wr_ok && aw_addr_reg == wrs_pkg::REG_MDATA
                  && !(is_fifo && level_reg == wrs_pkg::LVL_FULL);

  always_ff @(posedge aclk)
  begin
    if (mem_we)
      mem[is_fifo ? fifo_wp_reg : maddr_reg] <=
        wr_word[wrs_pkg::SMP_W-1:0];
    if (wr_ok && aw_addr_reg == wrs_pkg::REG_SDATA)
      seq_mem[saddr_reg] <=
        wrs_pkg::wrs_seq_t'(wr_word[wrs_pkg::SEQ_W-1:0]);
  end

  // Load pointers; each advances after a data write to its memory (fifo_wp_reg, not maddr_reg, in FIFO mode).
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd[wrs_pkg::CMD_STOP])
    begin
      maddr_reg   <= '0;
      fifo_wp_reg <= '0;
      saddr_reg   <= '0;
    end
    else if (wr_ok)
    begin
      if (aw_addr_reg == wrs_pkg::REG_MADDR)
        maddr_reg <= wr_word[wrs_pkg::MEM_AW-1:0];
      if (aw_addr_reg == wrs_pkg::REG_SADDR)
        saddr_reg <= wr_word[wrs_pkg::SEQ_AW-1:0];
      if (aw_addr_reg == wrs_pkg::REG_SDATA)
        saddr_reg <= saddr_reg + 4'h1;
      if (mem_we && is_fifo)
        fifo_wp_reg <= fifo_wp_reg + 8'h01;
      else if (mem_we)
        maddr_reg <= maddr_reg + 8'h01;
    end
  end

  // Pin inputs pass two flip-flops before any logic looks at them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
    end
    else
    begin
      trig_s1_reg <= trig_in;
      trig_s2_reg <= trig_s1_reg;
      gate_s1_reg <= gate_in;
      gate_s2_reg <= gate_s1_reg;
    end
  end

  // The active level is the selected edge's far side; the width counter
  // runs while the pulse is active and is judged when it ends.
  assign act = trig_s2_reg[ctrl_reg.trig_src[0]]
               ^ ctrl_reg.edge_fall;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_prev_reg <= 1'b0;
      pw_cnt_reg   <= '0;
    end
    else
    begin
      act_prev_reg <= act;
      if (act && !act_prev_reg)
        pw_cnt_reg <= 16'h0001;
      else if (act && pw_cnt_reg != wrs_pkg::PW_MAXV)
        pw_cnt_reg <= pw_cnt_reg + 16'h0001;
    end
  end

  always_comb
  begin
    unique case (ctrl_reg.pw_mode)
      wrs_pkg::PW_OFF: ext_evt = act && !act_prev_reg;
      wrs_pkg::PW_MIN: ext_evt = !act && act_prev_reg
                                 && pw_cnt_reg >= pw_reg;
      wrs_pkg::PW_MAX: ext_evt = !act && act_prev_reg
                                 && pw_cnt_reg <= pw_reg;
      default:         ext_evt = 1'b0;
    endcase
    unique case (ctrl_reg.trig_src)
      wrs_pkg::TSRC_SW:   trig_evt = cmd[wrs_pkg::CMD_SWTRIG];
      wrs_pkg::TSRC_EXT0,
      wrs_pkg::TSRC_EXT1: trig_evt = ext_evt;
      default:            trig_evt = 1'b0;
    endcase
  end

  // The clock output is half the sampling rate, the fastest a flip-flop
  // can drive without gating the clock itself.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_out <= 1'b0;
      clk_out  <= 1'b0;
    end
    else
    begin
      trig_out <= trig_evt && ctrl_reg.trig_out_en;
      clk_out  <= ctrl_reg.clk_out_en && !clk_out;
    end
  end

  // FIFO fill level; a write and a read in one cycle cancel.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmd[wrs_pkg::CMD_STOP])
    begin
      level_reg <= '0;
      fill_req  <= 1'b0;
    end
    else
    begin
      level_reg <= level_reg + 9'(mem_we && is_fifo)
                   - 9'(step && is_fifo);
      fill_req  <= is_fifo && state_reg != wrs_pkg::ST_IDLE
                   && level_reg <= wrs_pkg::LVL_HALF;
    end
  end

  assign ent      = seq_mem[seq_idx_reg];
  assign reg_last = is_seq ? ent.last : last_reg;
  assign rd_addr  = (is_seq ? ent.start : base_reg) + off_reg;

  always_comb
  begin
    step = 1'b0;
    if (state_reg == wrs_pkg::ST_PLAY)
    begin
      unique case (ctrl_reg.mode)
        wrs_pkg::MODE_GATED:
          step = gate_s2_reg == ctrl_reg.gate_level;
        wrs_pkg::MODE_FIFO: step = level_reg != '0;
        default:            step = 1'b1;
      endcase
    end
  end

  // Replay engine.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg   <= wrs_pkg::ST_IDLE;
      off_reg     <= '0;
      base_reg    <= '0;
      pass_reg    <= '0;
      seg_reg     <= '0;
      loop_reg    <= '0;
      seq_idx_reg <= '0;
      smp_out     <= '0;
    end
    else
    begin
      smp_out.valid <= 1'b0;
      if (cmd[wrs_pkg::CMD_STOP])
        state_reg <= wrs_pkg::ST_IDLE;
      else
      begin
        unique case (state_reg)
          wrs_pkg::ST_IDLE, wrs_pkg::ST_DONE:
            if (cmd[wrs_pkg::CMD_ARM])
            begin
              state_reg   <= wrs_pkg::ST_ARMED;
              off_reg     <= '0;
              base_reg    <= '0;
              pass_reg    <= '0;
              seg_reg     <= '0;
              loop_reg    <= '0;
              seq_idx_reg <= '0;
            end
          wrs_pkg::ST_ARMED, wrs_pkg::ST_WAIT:
            if (trig_evt)
              state_reg <= wrs_pkg::ST_PLAY;
          wrs_pkg::ST_PLAY:
            if (is_seq && cmd[wrs_pkg::CMD_JUMP])
            begin
              seq_idx_reg <= cmd[wrs_pkg::CMD_IDX_LSB +: 4];
              off_reg     <= '0;
              loop_reg    <= '0;
            end
            else if (step)
            begin
              smp_out.valid <= 1'b1;
              smp_out.data  <= mem[rd_addr];
              if (is_fifo || off_reg != reg_last)
                off_reg <= off_reg + 8'h01;
              else
              begin
                off_reg <= '0;
                unique case (ctrl_reg.mode)
                  wrs_pkg::MODE_ONESHOT:
                    state_reg <= wrs_pkg::ST_DONE;
                  wrs_pkg::MODE_REPEAT:
                    if (loops_reg != '0
                        && pass_reg == loops_reg - 16'h0001)
                      state_reg <= wrs_pkg::ST_DONE;
                    else
                      pass_reg <= pass_reg + 16'h0001;
                  wrs_pkg::MODE_RESTART:
                    state_reg <= wrs_pkg::ST_ARMED;
                  wrs_pkg::MODE_MULTI:
                  begin
                    state_reg <= wrs_pkg::ST_ARMED;
                    if (seg_reg == nseg_reg)
                    begin
                      seg_reg  <= '0;
                      base_reg <= '0;
                    end
                    else
                    begin
                      seg_reg  <= seg_reg + 4'h1;
                      base_reg <= base_reg + last_reg + 8'h01;
                    end
                  end
                  wrs_pkg::MODE_GATED: ;
                  wrs_pkg::MODE_SEQ:
                    if (loop_reg == ent.loops)
                    begin
                      loop_reg    <= '0;
                      seq_idx_reg <= ent.next;
                      if (ent.wait_trig)
                        state_reg <= wrs_pkg::ST_WAIT;
                    end
                    else
                      loop_reg <= loop_reg + 8'h01;
                  default:
                    state_reg <= wrs_pkg::ST_DONE;
                endcase
              end
            end
        endcase
      end
    end
  end

endmodule // wrs_sequencer

// *** testbench/wrs_sequencer_chk.sv ***
// Bus and output checks of the waveform replay sequencer.
module wrs_sequencer_chk (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [wrs_pkg::DATA_W-1:0]   s_axi_rdata,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire logic                         trig_out,
  input wire logic                         clk_out,
  input wire wrs_pkg::wrs_smp_t            smp_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("Write response dropped early.");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("Read response changed early.");
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans)
    else $error("Write response late.");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans)
    else $error("Read response late.");
  property p_wlow;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wlow: assert property (p_wlow)
    else $error("Write accepted while response pending.");
  property p_tpls; trig_out |=> !trig_out; endproperty
  a_tpls: assert property (p_tpls)
    else $error("Trigger output pulse too long.");
  property p_clko; clk_out |=> !clk_out; endproperty
  a_clko: assert property (p_clko)
    else $error("Clock output did not toggle.");
  property p_hold; !smp_out.valid |=> $stable(smp_out.data) || smp_out.valid;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Sample data changed without a sample.");
endmodule // wrs_sequencer_chk

bind wrs_sequencer wrs_sequencer_chk i_wrs_sequencer_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .trig_out, .clk_out, .smp_out);

// *** testbench/wrs_pin_src.sv ***
// External trigger source that drives pulses of a chosen width.
module wrs_pin_src (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [15:0] wid,
  output logic             trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_reg = 16'h0000;
  // Widths are whole cycles so the qualifier sees exact figures.
  always @(posedge aclk)
    if (go)
      left_reg <= wid;
    else if (left_reg != 16'h0000)
      left_reg <= left_reg - 16'h0001;
  assign trig = (left_reg != 16'h0000);
endmodule // wrs_pin_src

// *** testbench/tb_top.sv ***
// Self-checking testbench of the waveform replay sequencer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} wrs_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
  logic [15:0] wid = 16'h0000;
  logic        pin0, gate = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, trig_out, clk_out, fill_req;
  logic [1:0]  trig_in, s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  wrs_pkg::wrs_smp_t smp_out;
  int          failures = 0, n_compared = 0, n_smp = 0, n_to = 0, k;
  wrs_row_t    rows [5] = '{
    '{wrs_pkg::REG_CTRL,  32'h0000_F810, 32'h0000_0010, wrs_pkg::RESP_OKAY},
    '{wrs_pkg::REG_PW,    32'h0001_0006, 32'h0000_0006, wrs_pkg::RESP_OKAY},
    '{wrs_pkg::REG_LAST,  32'h0000_0103, 32'h0000_0003, wrs_pkg::RESP_OKAY},
    '{wrs_pkg::REG_LOOPS, 32'h0001_0002, 32'h0000_0002, wrs_pkg::RESP_OKAY},
    '{8'h2C,              32'h0000_0001, 32'h0000_0000, wrs_pkg::RESP_SLVERR}};
  assign trig_in = {1'b0, pin0};
  initial
    forever #2.5 aclk = ~aclk;
  wrs_sequencer i_wrs_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trig_in, .gate_in(gate), .trig_out,
    .clk_out, .fill_req, .smp_out);
  wrs_pin_src i_wrs_pin_src (.aclk, .go, .wid, .trig(pin0));
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    chk(32'(i < 50), 32'h1);
    if (i == 50) give_verdict();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    chk(32'(i < 50), 32'h1);
    if (i == 50) give_verdict();
  endtask
  // Software trigger when the source field says so, else a pin pulse.
  task automatic run(input logic [31:0] c, input int nt,
                     input logic [15:0] w, input int es, input int et);
    wr(wrs_pkg::REG_CMD, 32'h0000_0002, wrs_pkg::RESP_OKAY);
    wr(wrs_pkg::REG_CTRL, c, wrs_pkg::RESP_OKAY);
    wr(wrs_pkg::REG_CMD, 32'h0000_0001, wrs_pkg::RESP_OKAY);
    n_smp = 0;
    n_to = 0;
    for (int t = 0; t < nt; t++)
    begin
      if (c[4])
        wr(wrs_pkg::REG_CMD, 32'h0000_0004, wrs_pkg::RESP_OKAY);
      else
      begin
        wid <= w;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
      end
      repeat (30) @(posedge aclk);
    end
    @(negedge aclk);
    chk(n_smp, es);
    chk(n_to, et);
  endtask
  always @(posedge aclk)
    if (smp_out.valid === 1'b1)
    begin
      chk(32'(smp_out.data), 32'h1000 + n_smp % 4);
      n_smp++;
    end
  always @(posedge aclk)
    if (trig_out === 1'b1) n_to++;
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({17'h0, smp_out}, 32'h0);
    chk({29'h0, trig_out, clk_out, fill_req}, 32'h0);
    rd(wrs_pkg::REG_STATUS, 32'h0, wrs_pkg::RESP_OKAY);
    foreach (rows[j])
    begin
      wr(rows[j].a, rows[j].d, rows[j].r);
      rd(rows[j].a, rows[j].e, rows[j].r);
    end
    for (k = 0; k < 4; k++)
      wr(wrs_pkg::REG_MDATA, 32'h1000 + k, wrs_pkg::RESP_OKAY);
    run(32'h010, 2, 16'h0, 4, 0);
    run(32'h011, 2, 16'h0, 8, 0);
    run(32'h012, 2, 16'h0, 8, 0);
    run(32'h600, 1, 16'h4, 4, 1);
    run(32'h240, 1, 16'h4, 4, 1);
    run(32'h280, 1, 16'h3, 0, 0);
    run(32'h280, 1, 16'h8, 4, 1);
    run(32'h300, 1, 16'h8, 0, 0);
    run(32'h300, 1, 16'h4, 4, 1);
    run(32'h014, 2, 16'h0, 8, 0);
    run(32'h013, 1, 16'h0, 0, 0);
    chk(fill_req, 32'h1);
    for (k = 0; k < 4; k++)
      wr(wrs_pkg::REG_MDATA, 32'h1000 + k, wrs_pkg::RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk(n_smp, 4);
    run(32'h035, 1, 16'h0, 0, 0);
    @(posedge aclk) gate <= 1'b1;
    run(32'h035, 1, 16'h0, 30, 0);
    wr(wrs_pkg::REG_SDATA, 32'h0000_0300, wrs_pkg::RESP_OKAY);
    run(32'h016, 1, 16'h0, 30, 0);
    wr(wrs_pkg::REG_LOOPS, 32'h0, wrs_pkg::RESP_OKAY);
    run(32'h011, 1, 16'h0, 30, 0);
    wr(wrs_pkg::REG_CMD, 32'h0000_0002, wrs_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    k = n_smp;
    repeat (20) @(posedge aclk);
    chk(n_smp, k);
    aresetn <= 1'b0;
    @(posedge aclk) aresetn <= 1'b1;
    rd(wrs_pkg::REG_CTRL, 32'h0, wrs_pkg::RESP_OKAY);
    give_verdict();
  end
endmodule // tb_top
